// >>> hdl/pss_supervisor.sv
// Functional notes
// - save low under 14 V or bus-low 2 ms
// - host hold low under 12 V
// - both open-drain outputs only pull low
// - save low on thermal warning; host reads status
// - shutdown: Reset, latch flag, supplies off
// - shutdown gone: Start-Up, then Stand-By
// - warning self-clears; shutdown flag clears on read
// - host rewrites enable bit before timeout
// - early or missing rewrite pulls host low
// - period code selects timeout and minimum
// - Reset waits 10 V, enables fixed converter
// - rail 2.8 V plus trim: Stand-By, release
// - bus good set on Stand-By entry
// - oscillator starts 2 ms after Stand-By
// - rails start above filter high threshold
// - Normal only when all good, release save
// - filtered bus loss: Stand-By, save low
// - below filter low threshold: rails off
// - under 6.5 V fixed off, then Reset
// - Reset/Start-Up inactive; Stand-By 4 MHz clock
// - from Normal keep clock/rails unless cause
// - Normal host clock 8 or 16 MHz
`timescale 1ns/1ps
module pss_supervisor
   import pss_pkg::*;
#(
   parameter int MS_CYCLES      = MS_CYC,
   parameter int BUS_FILTER_CYC_P = BUS_FILTER_CYC
)(
   input  wire logic       clk,
   input  wire logic       rstn,
   input  wire pss_mon_s   mon_raw,
   input  wire logic       trim_done,
   input  wire logic       host_clock_select,
   input  wire logic       wd_write,
   input  wire logic       watchdog_enable_bit,
   input  wire logic [3:0] watchdog_period_code,
   input  wire logic       shutdown_flag_read,
   input  wire logic       host_hold_low_n_in,
   input  wire logic       save_warning_n_in,
   output logic            host_hold_low_n_out,
   output logic            host_hold_low_n_oe,
   output logic            save_warning_n_out,
   output logic            save_warning_n_oe,
   output pss_state_e      state_r,
   output logic            fixed_converter_en_r,
   output logic            adjustable_converter_en_r,
   output logic            linear_20v_en_r,
   output logic            osc_en_r,
   output pss_clk_rate_e   host_clock_out_r,
   output logic            host_if_active_r,
   output logic            bus_if_active_r,
   output logic            bus_voltage_good_r,
   output logic            filtered_supply_r,
   output logic            thermal_warning_r,
   output logic            thermal_shutdown_r,
   output logic            watchdog_on_r
);

   // ***********************************
   // synchronised inputs and ms tick
   // ***********************************
   pss_mon_s        m;
   logic [MS_W-1:0] ms_cnt_r;
   logic            ms_tick_r;

   pss_sync u_sync (
      .clk  (clk),
      .rstn (rstn),
      .d    (mon_raw),
      .q    (m)
   );

   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         ms_cnt_r  <= '0;
         ms_tick_r <= 1'b0;
      end
      else
      begin
         ms_tick_r <= ms_cnt_r == MS_W'(MS_CYCLES - 1);
         ms_cnt_r  <= (ms_cnt_r == MS_W'(MS_CYCLES - 1)) ? '0 : ms_cnt_r + 1'b1;
      end
   end

   // ***********************************
   // bus loss filters
   // ***********************************
   // pin values are ignored: the outputs only ever pull low
   logic [BF_W-1:0] bf_cnt_r;
   logic            bus_lost_r;
   logic [1:0]      bus20_ms_r;
   logic            bus20_low_r;

   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         bf_cnt_r   <= '0;
         bus_lost_r <= 1'b0;
      end
      else if (m.bus_above_low)
      begin
         bf_cnt_r   <= '0;
         bus_lost_r <= 1'b0;
      end
      else if (bf_cnt_r == BF_W'(BUS_FILTER_CYC_P))
         bus_lost_r <= 1'b1;
      else
         bf_cnt_r <= bf_cnt_r + 1'b1;
   end

   // ms granularity: trips between 1 and 2 ms, never later than 2 ms
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         bus20_ms_r  <= '0;
         bus20_low_r <= 1'b0;
      end
      else if (m.bus_above_20v)
      begin
         bus20_ms_r  <= '0;
         bus20_low_r <= 1'b0;
      end
      else if (bus20_ms_r == 2'(SAVE_BUS_MS))
         bus20_low_r <= 1'b1;
      else if (ms_tick_r)
         bus20_ms_r <= bus20_ms_r + 1'b1;
   end

   // ***********************************
   // watchdog
   // ***********************************
   logic      wd_fault;
   logic      wd_hold_r;
   logic [1:0] wd_hold_ms_r;

   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
         watchdog_on_r <= 1'b0;
      else if (state_r == PSS_RESET || state_r == PSS_STARTUP)
         watchdog_on_r <= 1'b0;
      else if (wd_write)
         watchdog_on_r <= watchdog_enable_bit;
   end

   pss_wdog u_wdog (
      .clk         (clk),
      .rstn        (rstn),
      .ms_tick     (ms_tick_r),
      .enable      (watchdog_on_r),
      .period_code (watchdog_period_code),
      .rewrite     (wd_write && watchdog_enable_bit),
      .fault_r     (wd_fault)
   );

   // a fault holds the host low for a short stretch
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         wd_hold_r    <= 1'b0;
         wd_hold_ms_r <= '0;
      end
      else if (wd_fault)
      begin
         wd_hold_r    <= 1'b1;
         wd_hold_ms_r <= '0;
      end
      else if (wd_hold_r && ms_tick_r)
      begin
         wd_hold_ms_r <= wd_hold_ms_r + 1'b1;
         wd_hold_r    <= wd_hold_ms_r < 2'(WD_HOLD_MS);
      end
   end

   // ***********************************
   // status flags
   // ***********************************
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         thermal_warning_r  <= 1'b0;
         thermal_shutdown_r <= 1'b0;
      end
      else
      begin
         thermal_warning_r <= m.thermal_warning;
         if (m.thermal_shutdown)
            thermal_shutdown_r <= 1'b1;
         else if (shutdown_flag_read)
            thermal_shutdown_r <= 1'b0;
      end
   end

   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
         filtered_supply_r <= 1'b0;
      else if (m.filt_above_high)
         filtered_supply_r <= 1'b1;
      else if (!m.filt_above_low)
         filtered_supply_r <= 1'b0;
   end

   // ***********************************
   // state machine
   // ***********************************
   logic       all_good;
   logic       from_normal_r;
   logic       osc_cause_r;
   logic       rail_cause_r;
   logic [1:0] osc_ms_r;

   assign all_good = m.osc_running && !m.thermal_warning && !m.thermal_shutdown
                     && bus_voltage_good_r && filtered_supply_r
                     && m.adj_rail_good && m.lin20_rail_good;

   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         state_r              <= PSS_RESET;
         fixed_converter_en_r <= 1'b0;
         bus_voltage_good_r   <= 1'b0;
         from_normal_r        <= 1'b0;
         osc_cause_r          <= 1'b0;
         rail_cause_r         <= 1'b0;
      end
      else if (m.thermal_shutdown)
      begin
         state_r              <= PSS_RESET;
         fixed_converter_en_r <= 1'b0;
         bus_voltage_good_r   <= 1'b0;
      end
      else
      begin
         if (!m.bus_above_low && bus_lost_r)
            bus_voltage_good_r <= 1'b0;
         else if (m.bus_above_high && state_r != PSS_RESET && state_r != PSS_STARTUP)
            bus_voltage_good_r <= 1'b1;
         if (fixed_converter_en_r && !m.filt_above_6v5)
            fixed_converter_en_r <= 1'b0;
         if (rail_cause_r && ms_tick_r)
            rail_cause_r <= 1'b0;
         unique case (state_r)
            PSS_RESET:
               if (m.filt_above_10v)
               begin
                  fixed_converter_en_r <= 1'b1;
                  state_r              <= PSS_STARTUP;
               end
            PSS_STARTUP:
               if (m.fixed_rail_ok && trim_done)
               begin
                  state_r            <= PSS_STANDBY;
                  from_normal_r      <= 1'b0;
                  osc_cause_r        <= 1'b0;
                  bus_voltage_good_r <= m.bus_above_high;
               end
            PSS_STANDBY:
               if (all_good)
                  state_r <= PSS_NORMAL;
            PSS_NORMAL:
               if (!all_good || bus_lost_r)
               begin
                  state_r       <= PSS_STANDBY;
                  from_normal_r <= 1'b1;
                  osc_cause_r   <= !m.osc_running;
                  rail_cause_r  <= !m.adj_rail_good || !m.lin20_rail_good;
               end
         endcase
         if (state_r != PSS_RESET && !fixed_converter_en_r && !m.fixed_rail_ok)
            state_r <= PSS_RESET;
      end
   end

   // ***********************************
   // oscillator and rail enables
   // ***********************************
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         osc_en_r <= 1'b0;
         osc_ms_r <= '0;
      end
      else if (state_r == PSS_RESET || state_r == PSS_STARTUP)
      begin
         osc_en_r <= 1'b0;
         osc_ms_r <= '0;
      end
      else if (osc_ms_r == 2'(OSC_START_MS))
         osc_en_r <= 1'b1;
      else if (ms_tick_r)
         osc_ms_r <= osc_ms_r + 1'b1;
   end

   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         adjustable_converter_en_r <= 1'b0;
         linear_20v_en_r           <= 1'b0;
      end
      else
      begin
         adjustable_converter_en_r <= (state_r == PSS_STANDBY || state_r == PSS_NORMAL)
                                      && filtered_supply_r && !rail_cause_r;
         linear_20v_en_r           <= (state_r == PSS_STANDBY || state_r == PSS_NORMAL)
                                      && filtered_supply_r && !rail_cause_r;
      end
   end

   // ***********************************
   // host clock and interfaces
   // ***********************************
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         host_clock_out_r <= PSS_CLK_OFF;
         host_if_active_r <= 1'b0;
         bus_if_active_r  <= 1'b0;
      end
      else
      begin
         host_if_active_r <= state_r == PSS_STANDBY || state_r == PSS_NORMAL;
         bus_if_active_r  <= state_r == PSS_NORMAL;
         unique case (state_r)
            PSS_RESET, PSS_STARTUP:
               host_clock_out_r <= PSS_CLK_OFF;
            PSS_STANDBY:
               if (!from_normal_r || osc_cause_r)
                  host_clock_out_r <= PSS_CLK_4M;
               else
                  host_clock_out_r <= host_clock_select ? PSS_CLK_16M : PSS_CLK_8M;
            PSS_NORMAL:
               host_clock_out_r <= host_clock_select ? PSS_CLK_16M : PSS_CLK_8M;
         endcase
      end
   end

   // ***********************************
   // open-drain outputs
   // ***********************************
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         host_hold_low_n_out <= 1'b0;
         save_warning_n_out  <= 1'b0;
         host_hold_low_n_oe  <= 1'b1;
         save_warning_n_oe   <= 1'b1;
      end
      else
      begin
         host_hold_low_n_out <= 1'b0;
         save_warning_n_out  <= 1'b0;
         host_hold_low_n_oe  <= !m.filt_above_12v || wd_hold_r
                                || state_r == PSS_RESET || state_r == PSS_STARTUP;
         save_warning_n_oe   <= !m.filt_above_14v || bus20_low_r
                                || m.thermal_warning || state_r != PSS_NORMAL;
      end
   end

   // ***********************************
   // checks
   // ***********************************
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);

   sequence s_enter_standby;
      state_r == PSS_STARTUP ##1 state_r == PSS_STANDBY;
   endsequence

   a_save_filt_low : assert property (!m.filt_above_14v |=> save_warning_n_oe)
      else $error("save not pulled under 14 V");
   a_hold_filt_low : assert property (!m.filt_above_12v |=> host_hold_low_n_oe)
      else $error("host not held under 12 V");
   a_od_pull_only : assert property (!host_hold_low_n_out && !save_warning_n_out)
      else $error("open-drain drove high");
   a_save_on_warn : assert property (m.thermal_warning |=> save_warning_n_oe)
      else $error("save not pulled on warning");
   a_tsd_to_reset : assert property (m.thermal_shutdown |=> state_r == PSS_RESET
      && thermal_shutdown_r && !fixed_converter_en_r)
      else $error("shutdown not handled");
   a_release_host : assert property (s_enter_standby ##1 !wd_hold_r && m.filt_above_12v
      && state_r == PSS_STANDBY |=> !host_hold_low_n_oe)
      else $error("host not released in stand-by");
   a_osc_delay : assert property (s_enter_standby |-> !osc_en_r [*2])
      else $error("oscillator started early");
   a_normal_entry : assert property (state_r != PSS_NORMAL ##1 state_r == PSS_NORMAL
      |-> $past(all_good))
      else $error("normal entered without all good");
   a_rails_off : assert property (!filtered_supply_r |=> !adjustable_converter_en_r
      && !linear_20v_en_r)
      else $error("rails on below low threshold");
   a_normal_clock : assert property (state_r == PSS_NORMAL |=> host_clock_out_r
      == (($past(host_clock_select)) ? PSS_CLK_16M : PSS_CLK_8M))
      else $error("wrong host clock rate");

endmodule : pss_supervisor

// >>> hdl/pss_pkg.sv
package pss_pkg;

   // ***********************************
   // timing
   // ***********************************
   localparam int CLK_PERIOD_PS  = 5000;
   localparam int MS_PS          = 1000000000;
   localparam int MS_CYC         = MS_PS / CLK_PERIOD_PS;
   localparam int SAVE_BUS_MS    = 2;
   localparam int OSC_START_MS   = 2;
   localparam int BUS_FILTER_US  = 1000;
   localparam int BUS_FILTER_CYC = BUS_FILTER_US * 1000000 / CLK_PERIOD_PS;
   localparam int WD_HOLD_MS     = 1;
   localparam int MS_W           = 18;
   localparam int BF_W           = 20;
   localparam int WD_W           = 10;

   // ***********************************
   // watchdog table, in ms, per period code
   // ***********************************
   localparam logic [WD_W-1:0] WD_TIMEOUT_MS [16] = '{
      10'h021, 10'h042, 10'h062, 10'h083, 10'h0A4, 10'h0C5, 10'h0E5, 10'h106,
      10'h127, 10'h148, 10'h168, 10'h189, 10'h1AA, 10'h1CB, 10'h1EC, 10'h20C};
   localparam logic [WD_W-1:0] WD_MIN_MS [16] = '{
      10'h002, 10'h004, 10'h006, 10'h008, 10'h00A, 10'h00C, 10'h00E, 10'h010,
      10'h012, 10'h014, 10'h017, 10'h019, 10'h01B, 10'h01D, 10'h01E, 10'h01F};

   // ***********************************
   // types
   // ***********************************
   typedef enum logic [1:0] {PSS_RESET, PSS_STARTUP, PSS_STANDBY, PSS_NORMAL} pss_state_e;
   typedef enum logic [1:0] {PSS_CLK_OFF, PSS_CLK_4M, PSS_CLK_8M, PSS_CLK_16M} pss_clk_rate_e;

   // comparator and temperature levels, 1 = condition true
   typedef struct packed {
      logic filt_above_14v;
      logic filt_above_12v;
      logic filt_above_10v;
      logic filt_above_6v5;
      logic filt_above_high;
      logic filt_above_low;
      logic bus_above_20v;
      logic bus_above_high;
      logic bus_above_low;
      logic fixed_rail_ok;
      logic adj_rail_good;
      logic lin20_rail_good;
      logic osc_running;
      logic thermal_warning;
      logic thermal_shutdown;
   } pss_mon_s;

   localparam int MON_W = $bits(pss_mon_s);

endpackage : pss_pkg

// >>> hdl/pss_sync.sv
`timescale 1ns/1ps
module pss_sync
   import pss_pkg::*;
(
   input  wire logic             clk,
   input  wire logic             rstn,
   input  wire logic [MON_W-1:0] d,
   output logic      [MON_W-1:0] q
);

   // ***********************************
   // two-stage synchroniser per bit
   // ***********************************
   // first stage feeds only the second stage
   logic [MON_W-1:0] meta_r;

   genvar i;
   generate
      for (i = 0; i < MON_W; i++)
      begin : g_bit
         always_ff @(posedge clk or negedge rstn)
         begin
            if (!rstn)
            begin
               meta_r[i] <= 1'b0;
               q[i]      <= 1'b0;
            end
            else
            begin
               meta_r[i] <= d[i];
               q[i]      <= meta_r[i];
            end
         end
      end
   endgenerate

endmodule : pss_sync

// >>> hdl/pss_wdog.sv
`timescale 1ns/1ps
module pss_wdog
   import pss_pkg::*;
(
   input  wire logic       clk,
   input  wire logic       rstn,
   input  wire logic       ms_tick,
   input  wire logic       enable,
   input  wire logic [3:0] period_code,
   input  wire logic       rewrite,
   output logic            fault_r
);

   // ***********************************
   // ms counter since last restart
   // ***********************************
   logic [WD_W-1:0] cnt_r;
   logic            early;
   logic            late;

   assign early = rewrite && (cnt_r < WD_MIN_MS[period_code]);
   assign late  = cnt_r >= WD_TIMEOUT_MS[period_code];

   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
         cnt_r <= '0;
      else if (!enable || rewrite || late)
         cnt_r <= '0;
      else if (ms_tick)
         cnt_r <= cnt_r + 1'b1;
   end

   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
         fault_r <= 1'b0;
      else
         fault_r <= enable && (early || late);
   end

   // ***********************************
   // checks
   // ***********************************
   a_wd_early_fault : assert property (@(posedge clk) disable iff (!rstn)
      enable && rewrite && cnt_r < WD_MIN_MS[period_code] |=> fault_r)
      else $error("early rewrite did not fault");
   a_wd_timeout_code : assert property (@(posedge clk) disable iff (!rstn)
      enable && !rewrite && cnt_r == WD_TIMEOUT_MS[period_code] |=> fault_r && cnt_r == '0)
      else $error("timeout did not fault");
   a_wd_disabled_clear : assert property (@(posedge clk) disable iff (!rstn)
      !enable |=> cnt_r == '0 && !fault_r)
      else $error("disabled watchdog counted");

endmodule : pss_wdog

// >>> testbench/pss_host_model.sv
`timescale 1ns/1ps
module pss_host_model
   import pss_pkg::*;
(
   input  wire logic       clk,
   input  wire logic       hold_oe,
   input  wire logic       hold_out,
   input  wire logic       save_oe,
   input  wire logic       save_out,
   input  wire logic       warn_flag,
   output logic            hold_pin,
   output logic            save_pin,
   output logic            wd_write,
   output logic            wd_bit,
   output logic [3:0]      wd_code,
   output logic            flag_read,
   output logic            warn_seen
);

   // ***********************************
   // open-drain pins with pull-up
   // ***********************************
   assign hold_pin = hold_oe ? hold_out : 1'h1;
   assign save_pin = save_oe ? save_out : 1'h1;

   initial
   begin
      wd_write  = 1'h0;
      wd_bit    = 1'h0;
      wd_code   = 4'h0;
      flag_read = 1'h0;
      warn_seen = 1'h0;
   end

   // ***********************************
   // host reaction and requests
   // ***********************************
   // status is read two edges later, so a flag landing with the pin is not missed
   always @(negedge save_pin)
   begin
      @(posedge clk);
      @(posedge clk);
      warn_seen = warn_flag;
   end

   task automatic wd_cmd(input logic b, input logic [3:0] c);
      @(negedge clk);
      wd_code  = c;
      wd_bit   = b;
      wd_write = 1'h1;
      @(negedge clk);
      wd_write = 1'h0;
   endtask : wd_cmd

   task automatic read_flag();
      @(negedge clk);
      flag_read = 1'h1;
      @(negedge clk);
      flag_read = 1'h0;
   endtask : read_flag

endmodule : pss_host_model

// >>> testbench/power_supervisor_watchdog_test.sv
`timescale 1ns/1ps
module power_supervisor_watchdog_test
   import pss_pkg::*;
;
   localparam int MS = 20;
   localparam int BF = 10;

   logic          clk = 1'h0;
   logic          rstn = 1'h0;
   pss_mon_s      mon = '0;
   logic          trim_done = 1'h0;
   logic          host_clock_select = 1'h0;
   logic          hold_out, hold_oe, save_out, save_oe, fc_en, ac_en, l20_en, osc_en;
   logic          hif, bif, bgood, tw_r, tsd_r, wd_on, fsup;
   pss_state_e    state;
   pss_clk_rate_e hclk;
   logic          wd_write, wd_bit, flag_read, hold_pin, save_pin, warn_seen, seen;
   logic [3:0]    wd_code;
   int            errors = 0;
   int            tests_run = 0;
   int            to_ms [2] = '{33, 524};
   int            mn_ms [2] = '{2, 31};
   logic [3:0]    codes [2] = '{4'h0, 4'hF};

   always #2.5 clk = ~clk;

   pss_supervisor #(.MS_CYCLES(MS), .BUS_FILTER_CYC_P(BF)) dut_u (
      .clk(clk), .rstn(rstn), .mon_raw(mon), .trim_done(trim_done), .host_clock_select(host_clock_select),
      .wd_write(wd_write), .watchdog_enable_bit(wd_bit), .watchdog_period_code(wd_code),
      .shutdown_flag_read(flag_read), .host_hold_low_n_in(hold_pin), .save_warning_n_in(save_pin),
      .host_hold_low_n_out(hold_out), .host_hold_low_n_oe(hold_oe), .save_warning_n_out(save_out),
      .save_warning_n_oe(save_oe), .state_r(state), .fixed_converter_en_r(fc_en),
      .adjustable_converter_en_r(ac_en), .linear_20v_en_r(l20_en), .osc_en_r(osc_en),
      .host_clock_out_r(hclk), .host_if_active_r(hif), .bus_if_active_r(bif), .bus_voltage_good_r(bgood),
      .filtered_supply_r(fsup), .thermal_warning_r(tw_r), .thermal_shutdown_r(tsd_r), .watchdog_on_r(wd_on));

   pss_host_model host_u (
      .clk(clk), .hold_oe(hold_oe), .hold_out(hold_out), .save_oe(save_oe), .save_out(save_out),
      .warn_flag(tw_r), .hold_pin(hold_pin), .save_pin(save_pin), .wd_write(wd_write), .wd_bit(wd_bit),
      .wd_code(wd_code), .flag_read(flag_read), .warn_seen(warn_seen));

   // ***********************************
   // helpers
   // ***********************************
   task automatic chk1(input logic g, input logic e);
      tests_run++;
      if (g !== e)
      begin
         errors++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask : chk1

   task automatic chk2(input logic [1:0] g, input logic [1:0] e);
      tests_run++;
      if (g !== e)
      begin
         errors++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask : chk2

   task automatic settle(input int n);
      repeat (n) @(negedge clk);
   endtask : settle

   // bounded wait for the host hold pin to be pulled low
   task automatic wait_low(input int max, output logic s);
      s = 1'h0;
      for (int i = 0; i < max; i++)
      begin
         @(negedge clk);
         if (hold_pin === 1'h0)
         begin
            s = 1'h1;
            break;
         end
      end
   endtask : wait_low

   task automatic wrap_up();
      $display("comparisons %0d mismatches %0d", tests_run, errors);
      if (errors == 0 && tests_run > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : wrap_up

   // ***********************************
   // watchdog on the whole run
   // ***********************************
   // about twice the longest expected run
   initial
   begin
      #150000;
      errors++;
      wrap_up();
   end

   // ***********************************
   // tests
   // ***********************************
   initial
   begin
      settle(20);
      chk2(state, PSS_RESET);
      chk1(hold_pin, 1'h0);
      chk1(hold_out, 1'h0);
      chk2(hclk, PSS_CLK_OFF);
      rstn = 1'h1;
      mon.filt_above_14v = 1'h1;
      mon.filt_above_12v = 1'h1;
      mon.filt_above_10v = 1'h1;
      mon.filt_above_6v5 = 1'h1;
      settle(8);
      chk2(state, PSS_STARTUP);
      chk1(fc_en, 1'h1);
      chk1(hold_pin, 1'h0);
      chk1(hif, 1'h0);
      mon.fixed_rail_ok = 1'h1;
      mon.bus_above_20v = 1'h1;
      mon.bus_above_high = 1'h1;
      mon.bus_above_low = 1'h1;
      trim_done = 1'h1;
      settle(8);
      chk2(state, PSS_STANDBY);
      chk1(hold_pin, 1'h1);
      chk1(bgood, 1'h1);
      chk2(hclk, PSS_CLK_4M);
      chk1(hif, 1'h1);
      chk1(bif, 1'h0);
      chk1(osc_en, 1'h0);
      chk1(ac_en, 1'h0);
      settle(3 * MS);
      chk1(osc_en, 1'h1);
      mon.filt_above_high = 1'h1;
      mon.filt_above_low = 1'h1;
      settle(8);
      chk1(ac_en & l20_en, 1'h1);
      chk1(fsup, 1'h1);
      chk1(save_pin, 1'h0);
      mon.adj_rail_good = 1'h1;
      mon.lin20_rail_good = 1'h1;
      mon.osc_running = 1'h1;
      settle(8);
      chk2(state, PSS_NORMAL);
      chk1(save_pin, 1'h1);
      chk2(hclk, PSS_CLK_8M);
      chk1(bif, 1'h1);
      host_clock_select = 1'h1;
      settle(8);
      chk2(hclk, PSS_CLK_16M);
      $display("test power_up done");
      mon.filt_above_14v = 1'h0;
      settle(8);
      chk1(save_pin, 1'h0);
      chk1(hold_pin, 1'h1);
      mon.filt_above_12v = 1'h0;
      settle(8);
      chk1(hold_pin, 1'h0);
      mon.filt_above_14v = 1'h1;
      mon.filt_above_12v = 1'h1;
      settle(8);
      chk1(hold_pin & save_pin, 1'h1);
      mon.bus_above_20v = 1'h0;
      settle(MS / 2);
      chk1(save_pin, 1'h1);
      settle(3 * MS);
      chk1(save_pin, 1'h0);
      chk2(state, PSS_NORMAL);
      mon.bus_above_high = 1'h0;
      mon.bus_above_low = 1'h0;
      settle(6);
      chk2(state, PSS_NORMAL);
      settle(BF + 6);
      chk2(state, PSS_STANDBY);
      chk1(bgood, 1'h0);
      chk2(hclk, PSS_CLK_16M);
      chk1(ac_en, 1'h1);
      chk1(warn_seen, 1'h0);
      mon.bus_above_20v = 1'h1;
      mon.bus_above_high = 1'h1;
      mon.bus_above_low = 1'h1;
      settle(3 * MS);
      chk2(state, PSS_NORMAL);
      chk1(save_pin, 1'h1);
      $display("test supply_loss done");
      mon.thermal_warning = 1'h1;
      settle(8);
      chk1(save_pin, 1'h0);
      chk1(tw_r, 1'h1);
      chk1(warn_seen, 1'h1);
      mon.thermal_warning = 1'h0;
      settle(3 * MS);
      chk1(tw_r, 1'h0);
      chk2(state, PSS_NORMAL);
      mon.osc_running = 1'h0;
      settle(8);
      chk2(state, PSS_STANDBY);
      chk2(hclk, PSS_CLK_4M);
      mon.osc_running = 1'h1;
      settle(8);
      chk2(state, PSS_NORMAL);
      chk2(hclk, PSS_CLK_16M);
      $display("test warning done");
      for (int i = 0; i < 2; i++)
      begin
         host_u.wd_cmd(1'h1, codes[i]);
         settle((mn_ms[i] + 2) * MS);
         host_u.wd_cmd(1'h1, codes[i]);
         settle(10);
         chk1(hold_pin, 1'h1);
         settle((to_ms[i] - 3) * MS);
         chk1(hold_pin, 1'h1);
         wait_low(5 * MS, seen);
         chk1(seen, 1'h1);
         host_u.wd_cmd(1'h0, codes[i]);
         settle(4 * MS);
         chk1(hold_pin, 1'h1);
         chk1(wd_on, 1'h0);
      end
      host_u.wd_cmd(1'h1, 4'h0);
      settle(4 * MS);
      host_u.wd_cmd(1'h1, 4'h0);
      host_u.wd_cmd(1'h1, 4'h0);
      wait_low(10, seen);
      chk1(seen, 1'h1);
      host_u.wd_cmd(1'h0, 4'h0);
      settle(40 * MS);
      chk1(hold_pin, 1'h1);
      $display("test watchdog done");
      mon.thermal_warning = 1'h1;
      mon.thermal_shutdown = 1'h1;
      settle(8);
      chk2(state, PSS_RESET);
      chk1(tsd_r, 1'h1);
      chk1(fc_en | ac_en | l20_en, 1'h0);
      chk1(hold_pin, 1'h0);
      host_u.read_flag();
      settle(4);
      chk1(tsd_r, 1'h1);
      chk2(state, PSS_RESET);
      mon.thermal_shutdown = 1'h0;
      settle(12);
      chk2(state, PSS_STANDBY);
      chk1(hold_pin, 1'h1);
      chk1(tsd_r, 1'h1);
      host_u.read_flag();
      settle(4);
      chk1(tsd_r, 1'h0);
      mon.thermal_warning = 1'h0;
      settle(4 * MS);
      chk1(osc_en, 1'h1);
      chk2(state, PSS_NORMAL);
      $display("test shutdown done");
      mon.filt_above_high = 1'h0;
      mon.filt_above_low = 1'h0;
      settle(8);
      chk1(ac_en | l20_en, 1'h0);
      chk1(fsup, 1'h0);
      chk1(fc_en, 1'h1);
      mon.filt_above_14v = 1'h0;
      mon.filt_above_12v = 1'h0;
      mon.filt_above_10v = 1'h0;
      mon.filt_above_6v5 = 1'h0;
      settle(8);
      chk1(fc_en, 1'h0);
      mon.fixed_rail_ok = 1'h0;
      settle(8);
      chk2(state, PSS_RESET);
      chk1(hold_pin, 1'h0);
      $display("test power_down done");
      wrap_up();
   end

endmodule : power_supervisor_watchdog_test
